// ===== shared/lane_defines.svh
`ifndef LANE_DEFINES_SVH
`define LANE_DEFINES_SVH

`define MID_CODE        8'h00
`define RAMP_START      8'h00
`define STP_FRAME1_BASE 8'hFF
`define D21_5_OCTET     8'hB5
`define K28_5_OCTET     8'hBC
`define RPAT_LAST       4'hB
`define PRBS_SEED_MULT  23'h020401
`define LMODE_SC4       5'h04
`define LMODE_SC8       5'h05
`define LMODE_DC4       5'h06
`define LMODE_DC8       5'h07
`define LMODE_SC16      5'h11
`define LMODE_DC16      5'h12

`endif

// ===== shared/lane_pkg.sv
package lane_pkg;

  typedef enum logic [3:0] {
    TP_NONE   = 4'h0,
    TP_PRBS7  = 4'h1,
    TP_PRBS15 = 4'h2,
    TP_PRBS23 = 4'h3,
    TP_RAMP   = 4'h4,
    TP_STP    = 4'h5,
    TP_D215   = 4'h6,
    TP_K285   = 4'h7,
    TP_RILA   = 4'h8,
    TP_RPAT   = 4'h9
  } test_mode_e;

  typedef struct packed {
    logic [7:0] octet;
    logic       is_ctrl;
    logic       bypass;
  } lane_out_s;

  typedef struct packed {
    logic [22:0] st;
    logic [7:0]  oct;
  } prbs_s;

endpackage

// ===== design/serial_lane_test_pattern_gen.sv
`timescale 1ns/100ps
`include "lane_defines.svh"
module serial_lane_test_pattern_gen
  import lane_pkg::*;
(
  // Clock, reset, enable
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             clk_en,
  // Mode control
  input  wire logic [4:0]       lane_mode_select,
  input  wire logic [3:0]       test_pattern_select,
  input  wire logic             cfg_power_down,
  input  wire logic             power_down_pin,
  input  wire logic             calib_active,
  // Link layer status
  input  wire logic             ilas_done,
  input  wire logic             sync_req_n,
  // Sample frame
  input  wire logic [15:0][7:0] sample_in,
  // Lane streams
  output lane_out_s [7:0]       link_a_lanes,
  output lane_out_s [7:0]       link_b_lanes,
  output logic      [15:0]      lane_drv_en,
  output logic                  ilas_repeat,
  output logic                  cgs_start
);

  function automatic logic [3:0] lanes_per_link(input logic [4:0] m);
    case (m)
      `LMODE_SC4, `LMODE_DC4:   return 4'h2;
      `LMODE_SC8, `LMODE_DC8:   return 4'h4;
      `LMODE_SC16, `LMODE_DC16: return 4'h8;
      default:                  return 4'h0;
    endcase
  endfunction

  function automatic logic [22:0] prbs_seed(input logic [3:0] l);
    return 23'(({19'h0, l} + 23'h000001) * `PRBS_SEED_MULT);
  endfunction

  function automatic prbs_s prbs8(input logic [22:0] st, input test_mode_e m);
    logic [22:0] s;
    logic [7:0]  o;
    logic        nb;
    s = st;
    o = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      case (m)
        TP_PRBS7:  nb = s[5] ^ s[6];
        TP_PRBS15: nb = s[13] ^ s[14];
        default:   nb = s[17] ^ s[22];
      endcase
      s = {s[21:0], nb};
      o = {o[6:0], nb}; // Oldest bit lands in the MSB
    end
    return '{st: s, oct: o};
  endfunction

  function automatic logic [7:0] rpat_octet(input logic [3:0] i);
    case (i)
      4'h0:    return 8'hBE;
      4'h1:    return 8'hD7;
      4'h2:    return 8'h23;
      4'h3:    return 8'h47;
      4'h4:    return 8'h6B;
      4'h5:    return 8'h8F;
      4'h6:    return 8'hB3;
      4'h7:    return 8'h14;
      4'h8:    return 8'h5E;
      4'h9:    return 8'hFB;
      4'hA:    return 8'h35;
      default: return 8'h59;
    endcase
  endfunction

  // Reset release
  logic [1:0] rsync_q;
  logic [1:0] rsync_d;
  logic       rst_n;

  always_comb
  begin
    rsync_d = {rsync_q[0], 1'b1};
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rsync_q <= 2'b00;
    else if (clk_en)
      rsync_q <= rsync_d;
  end

  assign rst_n = rsync_q[1];

  // Power-down pin filter; stage 0 feeds only stage 1
  logic [2:0] pds_q;
  logic [2:0] pds_d;
  logic       pd_q;
  logic       pd_d;

  always_comb
  begin
    pds_d = {pds_q[1:0], power_down_pin};
    pd_d  = (pds_q[1] == pds_q[2]) ? pds_q[1] : pd_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pds_q <= 3'h0;
      pd_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      pds_q <= pds_d;
      pd_q  <= pd_d;
    end
  end

  // Pattern state and lane outputs
  logic [15:0][22:0] prbs_q;
  logic [15:0][22:0] prbs_d;
  logic [7:0]        ramp_q;
  logic [7:0]        ramp_d;
  logic              frame_q;
  logic              frame_d;
  logic [3:0]        rpat_q;
  logic [3:0]        rpat_d;
  logic              sreq_q;
  logic              sreq_d;
  logic              cgs_q;
  logic              cgs_d;
  lane_out_s [15:0]  lanes_q;
  lane_out_s [15:0]  lanes_d;
  logic [15:0]       drv_q;
  logic [15:0]       drv_d;
  test_mode_e        tp;
  logic [3:0]        lpl;
  logic              single;
  logic              is_prbs;
  prbs_s             p;
  logic [3:0]        idx;

  always_comb
  begin
    tp      = test_mode_e'(test_pattern_select);
    lpl     = lanes_per_link(lane_mode_select);
    single  = lane_mode_select inside {`LMODE_SC4, `LMODE_SC8, `LMODE_SC16};
    is_prbs = tp inside {TP_PRBS7, TP_PRBS15, TP_PRBS23};
    ramp_d  = (tp == TP_RAMP && ilas_done) ? 8'(ramp_q + 8'h01) : `RAMP_START;
    frame_d = (tp == TP_STP) ? ~frame_q : 1'b0;
    rpat_d  = (tp != TP_RPAT || rpat_q == `RPAT_LAST) ? 4'h0 : 4'(rpat_q + 4'h1);
    sreq_d  = sync_req_n;
    cgs_d   = (tp == TP_RILA) && sreq_q && !sync_req_n;
    p       = '0;
    idx     = 4'h0;
    for (int l = 0; l < 16; l++)
    begin
      p         = prbs8(prbs_q[l], tp);
      prbs_d[l] = (is_prbs && prbs_q[l] != '0) ? p.st : prbs_seed(4'(l));
      // Single-channel interleaves: lane k of A is 2k, of B is 2k+1
      idx = single ? {3'(l), 1'(l / 8)} : 4'(l);
      lanes_d[l] = '0;
      case (tp)
        TP_PRBS7, TP_PRBS15, TP_PRBS23:
        begin
          lanes_d[l].octet  = p.oct;
          lanes_d[l].bypass = 1'b1;
        end
        TP_RAMP:  lanes_d[l].octet = ramp_q;
        TP_STP:   lanes_d[l].octet = frame_q ? 8'(`STP_FRAME1_BASE - 8'(l % 8))
                                             : 8'(l % 8);
        TP_D215:  lanes_d[l].octet = `D21_5_OCTET;
        TP_K285:
        begin
          lanes_d[l].octet   = `K28_5_OCTET;
          lanes_d[l].is_ctrl = 1'b1;
        end
        TP_RPAT:  lanes_d[l].octet = rpat_octet(rpat_q);
        // Lane alignment octets come from the link layer in this mode
        TP_RILA:  lanes_d[l].octet = `MID_CODE;
        default:  lanes_d[l].octet = calib_active ? `MID_CODE : sample_in[idx];
      endcase
      // Drivers follow lane mode and power-down, never the pattern
      drv_d[l] = (4'(l % 8) < lpl) && !pd_q && !cfg_power_down;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prbs_q  <= '0;
      ramp_q  <= `RAMP_START;
      frame_q <= 1'b0;
      rpat_q  <= 4'h0;
      sreq_q  <= 1'b1;
      cgs_q   <= 1'b0;
      lanes_q <= '0;
      drv_q   <= 16'h0000;
    end
    else if (clk_en)
    begin
      prbs_q  <= prbs_d;
      ramp_q  <= ramp_d;
      frame_q <= frame_d;
      rpat_q  <= rpat_d;
      sreq_q  <= sreq_d;
      cgs_q   <= cgs_d;
      lanes_q <= lanes_d;
      drv_q   <= drv_d;
    end
  end

  assign link_a_lanes = lanes_q[7:0];
  assign link_b_lanes = lanes_q[15:8];
  assign lane_drv_en  = drv_q;
  assign cgs_start    = cgs_q;
  assign ilas_repeat  = (test_pattern_select == TP_RILA);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_pd_off;
    clk_en && (pd_q || cfg_power_down) |=> lane_drv_en == 16'h0000;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("Drivers on in power-down");
  property p_high_lanes_off;
    clk_en && lane_mode_select == `LMODE_SC8
      |=> lane_drv_en[7:4] == 4'h0 && lane_drv_en[15:12] == 4'h0;
  endproperty
  a_high_lanes_off: assert property (p_high_lanes_off) else $error("Upper lanes on");
  property p_mode_drv;
    clk_en && lane_mode_select == `LMODE_SC16 && !pd_q && !cfg_power_down
      |=> lane_drv_en == 16'hFFFF;
  endproperty
  a_mode_drv: assert property (p_mode_drv) else $error("Lane drivers not per mode");
  property p_d215;
    clk_en && test_pattern_select == TP_D215 |=> link_b_lanes[5].octet == `D21_5_OCTET;
  endproperty
  a_d215: assert property (p_d215) else $error("D21.5 missing");
  property p_k285;
    clk_en && test_pattern_select == TP_K285
      |=> link_a_lanes[2].octet == `K28_5_OCTET && link_a_lanes[2].is_ctrl;
  endproperty
  a_k285: assert property (p_k285) else $error("K28.5 missing");
  property p_prbs_bypass;
    clk_en && test_pattern_select inside {TP_PRBS7, TP_PRBS15, TP_PRBS23}
      |=> link_a_lanes[0].bypass && link_b_lanes[7].bypass;
  endproperty
  a_prbs_bypass: assert property (p_prbs_bypass) else $error("PRBS not bypassing");
  property p_rpat;
    clk_en && test_pattern_select == TP_RPAT ##1
      clk_en && test_pattern_select == TP_RPAT && link_a_lanes[0].octet == 8'hBE
      |=> link_a_lanes[0].octet == 8'hD7;
  endproperty
  a_rpat: assert property (p_rpat) else $error("RPAT order wrong");
  property p_ramp;
    clk_en && test_pattern_select == TP_RAMP && ilas_done ##1
      clk_en && test_pattern_select == TP_RAMP
      |=> link_a_lanes[0].octet == 8'($past(link_a_lanes[0].octet) + 8'h01);
  endproperty
  a_ramp: assert property (p_ramp) else $error("Ramp step wrong");
  property p_stp;
    clk_en && test_pattern_select == TP_STP ##1
      clk_en && test_pattern_select == TP_STP && link_a_lanes[1].octet == 8'h01
      |=> link_a_lanes[1].octet == 8'hFE;
  endproperty
  a_stp: assert property (p_stp) else $error("Short transport wrong");
  property p_cal;
    clk_en && test_pattern_select == TP_NONE && calib_active
      |=> link_a_lanes[0].octet == `MID_CODE && link_b_lanes[7].octet == `MID_CODE;
  endproperty
  a_cal: assert property (p_cal) else $error("Calibration data not mid-code");
  property p_map_sc;
    clk_en && test_pattern_select == TP_NONE && !calib_active && lane_mode_select == `LMODE_SC16
      |=> link_b_lanes[7].octet == $past(sample_in[15])
          && link_a_lanes[3].octet == $past(sample_in[6]);
  endproperty
  a_map_sc: assert property (p_map_sc) else $error("Single-channel map wrong");
  property p_map_dc;
    clk_en && test_pattern_select == TP_NONE && !calib_active && lane_mode_select == `LMODE_DC16
      |=> link_b_lanes[0].octet == $past(sample_in[8]);
  endproperty
  a_map_dc: assert property (p_map_dc) else $error("Dual-channel map wrong");
  property p_cgs;
    clk_en && test_pattern_select == TP_RILA && sreq_q && !sync_req_n |=> cgs_start;
  endproperty
  a_cgs: assert property (p_cgs) else $error("Sync request ignored");

  c_prbs: cover property (clk_en && test_pattern_select == TP_PRBS23 [*3]);
  c_ramp_wrap: cover property (link_a_lanes[0].octet == 8'hFF ##1 link_a_lanes[0].octet == 8'h00);
  c_cgs: cover property (cgs_start);

endmodule // serial_lane_test_pattern_gen

// ===== tb/lane_rx_model.sv
`timescale 1ns/100ps
module lane_rx_model
  import lane_pkg::*;
(
  // Clock
  input  wire logic        sys_clk,
  // Bench control
  input  wire logic        link_on,
  input  wire logic        sync_req,
  // Lane side
  input  wire logic [15:0] lane_drv_en,
  output logic             sync_req_n,
  output logic             data_ok
);
  logic [3:0] flush_q;
  // Link off holds a sync request, like a receiver that is not ready
  assign sync_req_n = link_on & ~sync_req;
  // Words after drivers return are stale, so they are dropped
  always_ff @(posedge sys_clk)
  begin
    if (lane_drv_en == 16'h0000)
      flush_q <= 4'hF;
    else if (flush_q != 4'h0)
      flush_q <= flush_q - 4'h1;
  end
  assign data_ok = (flush_q == 4'h0);
endmodule // lane_rx_model

// ===== tb/serial_lane_test_pattern_gen_bench.sv
`timescale 1ns/100ps
module serial_lane_test_pattern_gen_bench;
  import lane_pkg::*;
  logic            sys_clk = 1'b0;
  logic            nrst = 1'b0;
  logic [4:0]      lane_mode_select = 5'h12;
  logic [3:0]      test_pattern_select = 4'h0;
  logic            cfg_power_down = 1'b0;
  logic            power_down_pin = 1'b0;
  logic            calib_active = 1'b0;
  logic            ilas_done = 1'b0;
  logic            link_on = 1'b0;
  logic            sync_req = 1'b0;
  logic            clk_en = 1'b1;
  logic            data_ok;
  logic [15:0][7:0] sample_in = '0;
  lane_out_s [7:0] link_a_lanes;
  lane_out_s [7:0] link_b_lanes;
  logic [15:0]     lane_drv_en;
  logic            ilas_repeat;
  logic            cgs_start;
  logic            sync_req_n;
  int              errors = 0;
  int              n_tests = 0;
  int              cyc = 0;
  always #5 sys_clk = ~sys_clk;
  serial_lane_test_pattern_gen serial_lane_test_pattern_gen_inst (.sys_clk(sys_clk),
    .nrst(nrst), .clk_en(clk_en), .lane_mode_select(lane_mode_select),
    .test_pattern_select(test_pattern_select), .cfg_power_down(cfg_power_down),
    .power_down_pin(power_down_pin), .calib_active(calib_active), .ilas_done(ilas_done),
    .sync_req_n(sync_req_n), .sample_in(sample_in), .link_a_lanes(link_a_lanes),
    .link_b_lanes(link_b_lanes), .lane_drv_en(lane_drv_en), .ilas_repeat(ilas_repeat),
    .cgs_start(cgs_start));
  lane_rx_model lane_rx_model_inst (.sys_clk(sys_clk), .link_on(link_on),
    .sync_req(sync_req), .lane_drv_en(lane_drv_en), .sync_req_n(sync_req_n),
    .data_ok(data_ok));
  task finish_test;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task step;
    @(posedge sys_clk);
    #1;
  endtask
  // Pattern only moves while the link is down
  task set_tp(input logic [3:0] tp);
    link_on = 1'b0;
    step;
    test_pattern_select = tp;
    step;
    link_on = 1'b1;
  endtask
  function automatic int lanes_off(input logic [7:0] o);
    int b = 0;
    for (int k = 0; k < 8; k++)
      b += (link_a_lanes[k].octet !== o) + (link_b_lanes[k].octet !== o);
    return b;
  endfunction
  task t_map;
    int bad;
    logic [4:0] md[7] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h11, 5'h12, 5'h00};
    logic [15:0] en[7] = '{16'h0303, 16'h0F0F, 16'h0303, 16'h0F0F, 16'hFFFF, 16'hFFFF, 16'h0};
    for (int i = 0; i < 16; i++)
      sample_in[i] = 8'(i * 37 + 5);
    lane_mode_select = 5'h11;
    step;
    bad = 0;
    for (int k = 0; k < 8; k++)
      bad += (link_a_lanes[k].octet !== sample_in[2*k])
           + (link_b_lanes[k].octet !== sample_in[2*k+1]);
    chk(bad, 0, "single map");
    lane_mode_select = 5'h12;
    step;
    bad = 0;
    for (int k = 0; k < 8; k++)
      bad += (link_a_lanes[k].octet !== sample_in[k])
           + (link_b_lanes[k].octet !== sample_in[8+k]);
    chk(bad, 0, "dual map");
    calib_active = 1'b1;
    step;
    chk(lanes_off(8'h00), 0, "calib mid code");
    calib_active = 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      lane_mode_select = md[i];
      step;
      chk(lane_drv_en, en[i], "lane enables");
    end
    lane_mode_select = 5'h12;
    step;
    $display("map test done");
  endtask
  task t_pd;
    int n;
    cfg_power_down = 1'b1;
    step;
    chk(lane_drv_en, 16'h0, "cfg power down");
    cfg_power_down = 1'b0;
    step;
    chk(lane_drv_en, 16'hFFFF, "cfg power up");
    power_down_pin = 1'b1;
    step;
    step;
    chk(lane_drv_en, 16'hFFFF, "pin filtered");
    n = 0;
    while (lane_drv_en !== 16'h0 && n < 8)
    begin
      step;
      n++;
    end
    chk(lane_drv_en, 16'h0, "pin power down");
    power_down_pin = 1'b0;
    repeat (8) step;
    chk(lane_drv_en, 16'hFFFF, "pin power up");
    chk(data_ok, 1'b0, "stale data dropped");
    repeat (16) step;
    chk(data_ok, 1'b1, "data accepted after flush");
    $display("power down test done");
  endtask
  task t_streams;
    int bad;
    logic [7:0] hold;
    logic [7:0] rp[12] = '{8'hBE, 8'hD7, 8'h23, 8'h47, 8'h6B, 8'h8F, 8'hB3, 8'h14,
                           8'h5E, 8'hFB, 8'h35, 8'h59};
    ilas_done = 1'b0;
    set_tp(TP_RAMP);
    step;
    chk(lanes_off(8'h00), 0, "ramp held");
    ilas_done = 1'b1;
    step;
    bad = 0;
    for (int i = 0; i < 300; i++)
    begin
      bad += lanes_off(8'(i));
      step;
    end
    chk(bad, 0, "ramp count");
    // Enable low must freeze the running ramp
    clk_en = 1'b0;
    hold = link_a_lanes[3].octet;
    repeat (3) step;
    chk(lanes_off(hold), 0, "clock enable freeze");
    clk_en = 1'b1;
    set_tp(TP_STP);
    bad = 0;
    for (int i = 0; i < 4; i++)
    begin
      for (int k = 0; k < 8; k++)
        bad += (link_a_lanes[k].octet !== (i % 2 ? 8'(255 - k) : 8'(k)))
             + (link_b_lanes[k].octet !== (i % 2 ? 8'(255 - k) : 8'(k)));
      step;
    end
    chk(bad, 0, "short transport");
    set_tp(TP_RPAT);
    bad = 0;
    for (int i = 0; i < 24; i++)
    begin
      bad += lanes_off(rp[i % 12]);
      step;
    end
    chk(bad, 0, "rpat");
    set_tp(TP_D215);
    chk(lanes_off(8'hB5) + (link_a_lanes[0].is_ctrl !== 1'b0), 0, "d21.5");
    set_tp(TP_K285);
    chk(lanes_off(8'hBC) + (link_b_lanes[7].is_ctrl !== 1'b1), 0, "k28.5");
    $display("stream test done");
  endtask
  task t_prbs(input logic [3:0] tp, input int t1, input int t2);
    logic [63:0] s0;
    logic [63:0] s1;
    int bad;
    set_tp(tp);
    bad = 0;
    for (int i = 0; i < 8; i++)
    begin
      s0 = {s0[55:0], link_a_lanes[0].octet};
      s1 = {s1[55:0], link_b_lanes[7].octet};
      bad += (link_a_lanes[0].bypass !== 1'b1);
      step;
    end
    for (int n = t2; n < 64; n++)
      bad += (s0[63-n] !== (s0[63-n+t1] ^ s0[63-n+t2]));
    chk(bad, 0, "prbs recurrence");
    chk(s0 != s1 && s0 != 64'h0, 1, "prbs lane phase");
    chk(lane_drv_en, 16'hFFFF, "drivers follow lane mode");
    $display("prbs test done");
  endtask
  task t_rila;
    int n;
    set_tp(TP_RILA);
    chk(ilas_repeat, 1'b1, "repeat flag");
    // Request only counts after a high sample
    step;
    sync_req = 1'b1;
    n = 0;
    repeat (6)
    begin
      step;
      n += (cgs_start === 1'b1);
    end
    chk(n, 1, "one cgs pulse");
    sync_req = 1'b0;
    set_tp(TP_NONE);
    chk(ilas_repeat, 1'b0, "repeat flag off");
    $display("repeat alignment test done");
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      finish_test;
    end
  end
  initial
  begin
    repeat (8) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    link_on = 1'b1;
    repeat (4) step;
    t_map;
    t_pd;
    t_streams;
    t_prbs(TP_PRBS7, 6, 7);
    t_prbs(TP_PRBS15, 14, 15);
    t_prbs(TP_PRBS23, 18, 23);
    t_rila;
    finish_test;
  end
endmodule // serial_lane_test_pattern_gen_bench
